//--- logic/smb_host.sv
/*
 * host end of the link: runs one byte or word, read or write, per command.
 * assumes the target never stretches the clock; the clock is a divided copy
 * of core_clk driven open-drain.
 */
module smb_host #(
   parameter int QTR = smb_pkg::QTR_CYCLES
) (
   input wire logic core_clk, // 25 MHz core clock
   input wire logic resetn, // asynchronous reset
   smb_link.host link, // serial link
   input wire logic cmd_valid, // command offered
   output logic cmd_ready, // command taken when valid
   input wire logic [1:0] cmd_op, // transfer kind
   input wire logic [6:0] cmd_addr, // target address
   input wire logic [7:0] cmd_code, // command code
   input wire logic [15:0] cmd_wdata, // write data, low byte first
   output logic rsp_done, // transfer finished
   output logic [15:0] rsp_rdata, // read data
   output logic rsp_nack // target failed to acknowledge
);
   import smb_pkg::*;

   localparam logic [15:0] DIV_LAST = 16'(QTR - 1);

   // ----------------------------------------------------------------
   // sequence table
   // ----------------------------------------------------------------
   function automatic host_state_e act_of(input logic [1:0] op, input logic [2:0] step);
      host_state_e a;
      unique case (step)
         STEP_START: a = H_START;
         STEP_ADDR, STEP_CMD: a = H_TX;
         STEP_LO: a = op[OP_READ_BIT] ? H_START : H_TX;
         STEP_HI: a = (op[OP_READ_BIT] | op[OP_WORD_BIT]) ? H_TX : H_STOP;
         STEP_RX_LO: a = op[OP_READ_BIT] ? H_RX : H_STOP;
         STEP_RX_HI: a = op[OP_WORD_BIT] ? H_RX : H_STOP;
         default: a = H_STOP;
      endcase
      return a;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic sda_m;
   logic sda_s;
   logic [15:0] div_q;
   logic [15:0] div_d;
   logic tick;
   host_state_e st_q;
   host_state_e st_d;
   logic [2:0] step_q;
   logic [2:0] step_d;
   logic [1:0] q_q;
   logic [1:0] q_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [1:0] op_q;
   logic [1:0] op_d;
   logic [6:0] addr_q;
   logic [6:0] addr_d;
   logic [7:0] code_q;
   logic [7:0] code_d;
   logic [15:0] wdata_q;
   logic [15:0] wdata_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic nack_q;
   logic nack_d;
   logic done_q;
   logic done_d;
   logic scl_low_q;
   logic scl_low_d;
   logic sda_low_q;
   logic sda_low_d;

   assign tick = (div_q == DIV_LAST);

   always_comb begin
      st_d = st_q;
      step_d = step_q;
      q_d = q_q;
      bit_d = bit_q;
      sh_d = sh_q;
      op_d = op_q;
      addr_d = addr_q;
      code_d = code_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      nack_d = nack_q;
      done_d = 1'b0;
      div_d = (st_q == H_IDLE || tick) ? 16'h0000 : div_q + 16'h0001;
      if (st_q == H_IDLE) begin
         if (cmd_valid) begin
            st_d = H_START;
            step_d = STEP_START;
            q_d = 2'h0;
            op_d = cmd_op;
            addr_d = cmd_addr;
            code_d = cmd_code;
            wdata_d = cmd_wdata;
            rdata_d = 16'h0000;
            nack_d = 1'b0;
         end
      end else if (tick) begin
         q_d = q_q + 2'h1;
         if (q_q == QTR_SAMPLE && st_q == H_RX && bit_q != BYTE_BITS) begin
            sh_d = {sh_q[6:0], sda_s};
         end
         if (q_q == QTR_SAMPLE && st_q == H_TX && bit_q == BYTE_BITS && sda_s) begin
            nack_d = 1'b1;
         end
         if (q_q == QTR_LAST) begin
            if ((st_q == H_TX || st_q == H_RX) && bit_q != BYTE_BITS) begin
               bit_d = bit_q + 4'h1;
               if (st_q == H_TX) begin
                  sh_d = {sh_q[6:0], 1'b0};
               end
            end else if (st_q == H_STOP) begin
               st_d = H_IDLE;
               done_d = 1'b1;
            end else if (nack_q) begin
               st_d = H_STOP;
            end else begin
               if (st_q == H_RX && step_q == STEP_RX_LO) begin
                  rdata_d[7:0] = sh_q;
               end
               if (st_q == H_RX && step_q == STEP_RX_HI) begin
                  rdata_d[15:8] = sh_q;
               end
               step_d = step_q + 3'h1;
               st_d = act_of(op_q, step_q + 3'h1);
               bit_d = 4'h0;
               unique case (step_q + 3'h1)
                  STEP_ADDR: sh_d = {addr_q, 1'b0};
                  STEP_CMD: sh_d = code_q;
                  STEP_LO: sh_d = wdata_q[7:0];
                  STEP_HI: sh_d = op_q[OP_READ_BIT] ? {addr_q, 1'b1} : wdata_q[15:8];
                  default: sh_d = sh_q;
               endcase
            end
         end
      end
      // open-drain levels for the coming quarter
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
      unique case (st_d)
         H_IDLE: begin
         end
         H_START: begin
            scl_low_d = (q_d == QTR_LAST);
            sda_low_d = (q_d >= QTR_SAMPLE);
         end
         H_STOP: begin
            scl_low_d = (q_d == 2'h0);
            sda_low_d = (q_d < QTR_SAMPLE);
         end
         H_TX: begin
            scl_low_d = (q_d == 2'h0) || (q_d == QTR_LAST);
            sda_low_d = (bit_d != BYTE_BITS) && !sh_d[7];
         end
         H_RX: begin
            scl_low_d = (q_d == 2'h0) || (q_d == QTR_LAST);
            // ack the low byte of a word, nack the final byte
            sda_low_d = (bit_d == BYTE_BITS) && step_q == STEP_RX_LO
                        && op_q[OP_WORD_BIT];
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sda_m <= SYNC_RST;
         sda_s <= SYNC_RST;
         div_q <= 16'h0000;
         st_q <= H_IDLE;
         step_q <= STEP_START;
         q_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         op_q <= OP_BYTE_WR;
         addr_q <= 7'h00;
         code_q <= 8'h00;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         nack_q <= 1'b0;
         done_q <= 1'b0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else begin
         sda_m <= link.sda;
         sda_s <= sda_m;
         div_q <= div_d;
         st_q <= st_d;
         step_q <= step_d;
         q_q <= q_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         op_q <= op_d;
         addr_q <= addr_d;
         code_q <= code_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         nack_q <= nack_d;
         done_q <= done_d;
         scl_low_q <= scl_low_d;
         sda_low_q <= sda_low_d;
      end
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = scl_low_q;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = sda_low_q;
   assign cmd_ready = (st_q == H_IDLE);
   assign rsp_done = done_q;
   assign rsp_rdata = rdata_q;
   assign rsp_nack = nack_q;
endmodule

//--- logic/smb_link.sv
/*
 * two-wire link joining the host end and the target end.
 * assumes open-drain wires with pull-ups: an enabled driver can only pull low.
 */
interface smb_link;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic tgt_sda_o;
   logic tgt_sda_oe;
   logic scl;
   logic sda;
   // wired-and of all enabled drivers
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (tgt_sda_oe & ~tgt_sda_o));
   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
   modport target (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface

//--- logic/smb_pkg.sv
/*
 * shared constants and state types for the serial link target and host ends.
 * assumes a single 25 MHz core clock and an open-drain two-wire link.
 */
package smb_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINK_PERIOD_NS = 10000;
   // longest quarter period, so rounded down
   localparam int QTR_CYCLES = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // ----------------------------------------------------------------
   // byte and command layout
   // ----------------------------------------------------------------
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam int CMD_INDEXED_BIT = 7;
   localparam int ADDR_RW_BIT = 0;
   // arbitrary default target address
   localparam logic [6:0] TARGET_ADDR_DEF = 7'h2a;
   localparam logic [6:0] OFFSET_RST = 7'h00;
   localparam logic SYNC_RST = 1'b1;
   // ----------------------------------------------------------------
   // host command codes and sequence steps
   // ----------------------------------------------------------------
   localparam int OP_WORD_BIT = 0;
   localparam int OP_READ_BIT = 1;
   localparam logic [1:0] OP_BYTE_WR = 2'h0;
   localparam logic [1:0] OP_WORD_WR = 2'h1;
   localparam logic [1:0] OP_BYTE_RD = 2'h2;
   localparam logic [1:0] OP_WORD_RD = 2'h3;
   localparam logic [2:0] STEP_START = 3'h0;
   localparam logic [2:0] STEP_ADDR = 3'h1;
   localparam logic [2:0] STEP_CMD = 3'h2;
   localparam logic [2:0] STEP_LO = 3'h3;
   localparam logic [2:0] STEP_HI = 3'h4;
   localparam logic [2:0] STEP_RX_LO = 3'h5;
   localparam logic [2:0] STEP_RX_HI = 3'h6;
   localparam logic [1:0] QTR_SAMPLE = 2'h2;
   localparam logic [1:0] QTR_LAST = 2'h3;
   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_CMD = 3'h3, ST_WDATA = 3'h2,
      ST_RDATA = 3'h6, ST_RACK = 3'h7, ST_SKIP = 3'h5
   } tgt_state_e;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_START = 3'h1, H_TX = 3'h3, H_RX = 3'h2, H_STOP = 3'h6
   } host_state_e;
endpackage

//--- logic/smb_target.sv
/*
 * target end of the link: indexed byte and word access into a configuration
 * byte array. assumes the array answers reg_rdata for reg_offset in the same
 * cycle and that the link runs well below an eighth of core_clk.
 */
module smb_target #(
   parameter logic [6:0] TARGET_ADDR = smb_pkg::TARGET_ADDR_DEF
) (
   input wire logic core_clk, // 25 MHz core clock
   input wire logic resetn, // asynchronous reset
   smb_link.target link, // serial link
   output logic [6:0] reg_offset, // byte array index
   output logic [7:0] reg_wdata, // byte to store
   output logic reg_wr, // store strobe
   input wire logic [7:0] reg_rdata, // byte at reg_offset
   output logic reg_rd, // read strobe
   output logic block_cmd, // block command seen
   output logic busy // transaction in progress
);
   import smb_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers and edge detection
   // ----------------------------------------------------------------
   logic scl_m;
   logic scl_s;
   logic scl_p;
   logic sda_m;
   logic sda_s;
   logic sda_p;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scl_m <= SYNC_RST;
         scl_s <= SYNC_RST;
         scl_p <= SYNC_RST;
         sda_m <= SYNC_RST;
         sda_s <= SYNC_RST;
         sda_p <= SYNC_RST;
      end else begin
         scl_m <= link.scl;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= link.sda;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   // data edges while the clock stays high frame a transaction
   assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

   // ----------------------------------------------------------------
   // transaction sequencer
   // ----------------------------------------------------------------
   tgt_state_e st_q;
   tgt_state_e st_d;
   tgt_state_e nxt_q;
   tgt_state_e nxt_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic drv_q;
   logic drv_d;
   logic ack_q;
   logic ack_d;
   logic nack_q;
   logic nack_d;
   logic [6:0] off_q;
   logic [6:0] off_d;
   logic [7:0] wdata_q;
   logic [7:0] wdata_d;
   logic wr_q;
   logic wr_d;
   logic rd_q;
   logic rd_d;
   logic blk_q;
   logic blk_d;
   logic load;

   always_comb begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      drv_d = drv_q;
      ack_d = ack_q;
      nack_d = nack_q;
      off_d = off_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      blk_d = 1'b0;
      load = 1'b0;
      // offset steps one cycle after each strobe so the strobe sees the old one
      if (wr_q || rd_q) begin
         off_d = off_q + 7'h01;
      end
      if (start_ev) begin
         // repeated start keeps the offset from the command phase
         st_d = ST_ADDR;
         cnt_d = 4'h0;
         drv_d = 1'b0;
         ack_d = 1'b0;
      end else if (stop_ev) begin
         st_d = ST_IDLE;
         drv_d = 1'b0;
         ack_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise && !ack_q && cnt_q != BYTE_BITS) begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && ack_q) begin
                  // end of the acknowledge slot: release and move on
                  ack_d = 1'b0;
                  drv_d = 1'b0;
                  cnt_d = 4'h0;
                  st_d = nxt_q;
                  load = (nxt_q == ST_RDATA);
               end else if (scl_fall && cnt_q == BYTE_BITS) begin
                  ack_d = 1'b1;
                  drv_d = 1'b1;
                  if (st_q == ST_ADDR) begin
                     if (sh_q[7:1] == TARGET_ADDR) begin
                        nxt_d = sh_q[ADDR_RW_BIT] ? ST_RDATA : ST_CMD;
                     end else begin
                        ack_d = 1'b0;
                        drv_d = 1'b0;
                        st_d = ST_SKIP;
                     end
                  end else if (st_q == ST_CMD) begin
                     if (sh_q[CMD_INDEXED_BIT]) begin
                        off_d = sh_q[6:0];
                        nxt_d = ST_WDATA;
                     end else begin
                        blk_d = 1'b1;
                        nxt_d = ST_SKIP;
                     end
                  end else begin
                     // each data byte is stored and acknowledged
                     wdata_d = sh_q;
                     wr_d = 1'b1;
                     nxt_d = ST_WDATA;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_q == LAST_BIT) begin
                     drv_d = 1'b0;
                     cnt_d = 4'h0;
                     st_d = ST_RACK;
                  end else begin
                     cnt_d = cnt_q + 4'h1;
                     sh_d = {sh_q[6:0], 1'b0};
                     drv_d = ~sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_d = sda_s;
               end else if (scl_fall) begin
                  if (nack_q) begin
                     st_d = ST_SKIP;
                  end else begin
                     st_d = ST_RDATA;
                     cnt_d = 4'h0;
                     load = 1'b1;
                  end
               end
            end
            ST_IDLE, ST_SKIP: begin
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
      if (load) begin
         // first bit goes out right away, the clock is low here
         sh_d = reg_rdata;
         drv_d = ~reg_rdata[7];
         rd_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         drv_q <= 1'b0;
         ack_q <= 1'b0;
         nack_q <= 1'b0;
         off_q <= OFFSET_RST;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         blk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         nxt_q <= nxt_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         drv_q <= drv_d;
         ack_q <= ack_d;
         nack_q <= nack_d;
         off_q <= off_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         blk_q <= blk_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.tgt_sda_o = 1'b0;
   assign link.tgt_sda_oe = drv_q;
   assign reg_offset = off_q;
   assign reg_wdata = wdata_q;
   assign reg_wr = wr_q;
   assign reg_rd = rd_q;
   assign block_cmd = blk_q;
   assign busy = (st_q != ST_IDLE);
endmodule

//--- test/smb_byte_word_access_target_tb.sv
/*
 * testbench: the host end runs byte and word transfers into the target end.
 * assumes the configuration array is modelled here and answers in the same cycle.
 */
module smb_byte_word_access_target_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import smb_pkg::*;

   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [6:0] cmd_addr = 7'h00;
   logic [7:0] cmd_code = 8'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic cmd_ready, rsp_done, rsp_nack, reg_wr, reg_rd, block_cmd, busy;
   logic [15:0] rsp_rdata, rd;
   logic [6:0] reg_offset;
   logic [7:0] reg_wdata, reg_rdata;
   logic [7:0] mem [0:127];
   logic nack;
   int err_total = 0;
   int check_count = 0;
   int wr_cnt = 0;
   int blk_cnt = 0;
   int wr0, blk0, rd0;
   int rd_cnt = 0;
   logic busy_seen = 1'b0;

   always #20 core_clk = ~core_clk;

   smb_link smb_link_inst ();
   smb_host #(.QTR(4)) smb_host_inst (
      .core_clk(core_clk), .resetn(resetn), .link(smb_link_inst.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_done(rsp_done),
      .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
   smb_target smb_target_inst (
      .core_clk(core_clk), .resetn(resetn), .link(smb_link_inst.target),
      .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rdata(reg_rdata), .reg_rd(reg_rd), .block_cmd(block_cmd), .busy(busy));
   smb_link_checker smb_link_checker_inst (
      .core_clk(core_clk), .resetn(resetn),
      .host_scl_o(smb_link_inst.host_scl_o), .host_scl_oe(smb_link_inst.host_scl_oe),
      .host_sda_o(smb_link_inst.host_sda_o), .host_sda_oe(smb_link_inst.host_sda_oe),
      .tgt_sda_o(smb_link_inst.tgt_sda_o), .tgt_sda_oe(smb_link_inst.tgt_sda_oe),
      .scl(smb_link_inst.scl), .sda(smb_link_inst.sda));

   // ----------------------------------------------------------------
   // configuration array and wire monitor
   // ----------------------------------------------------------------
   assign reg_rdata = mem[reg_offset];
   always @(posedge core_clk) begin
      if (reg_wr === 1'b1) begin
         mem[reg_offset] <= reg_wdata;
         wr_cnt <= wr_cnt + 1;
      end
      if (block_cmd === 1'b1) begin
         blk_cnt <= blk_cnt + 1;
      end
      if (reg_rd === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
      if (busy === 1'b1) begin
         busy_seen <= 1'b1;
      end
   end

   // keeps the address byte and its ack of the latest frame, msb first on the wire
   logic scl_p = 1'b1;
   logic sda_p = 1'b1;
   logic mon_first = 1'b0;
   logic mon_ack = 1'b1;
   logic [3:0] mon_cnt = 4'h0;
   logic [7:0] mon_sh = 8'h00;
   logic [7:0] mon_addr = 8'h00;
   always @(posedge core_clk) begin
      scl_p <= smb_link_inst.scl;
      sda_p <= smb_link_inst.sda;
      if (scl_p && smb_link_inst.scl && sda_p && !smb_link_inst.sda) begin
         mon_cnt <= 4'h0;
         mon_first <= 1'b1;
      end else if (!scl_p && smb_link_inst.scl && mon_first) begin
         if (mon_cnt < 4'h8) begin
            mon_sh <= {mon_sh[6:0], smb_link_inst.sda};
         end else begin
            mon_addr <= mon_sh;
            mon_ack <= smb_link_inst.sda;
            mon_first <= 1'b0;
         end
         mon_cnt <= mon_cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // entered just after an edge with the host idle; returns at the cycle of rsp_done
   task automatic run(input logic [1:0] op, input logic [6:0] addr, input logic [7:0] code,
                      input logic [15:0] wd, output logic [15:0] rdv, output logic nk);
      int n;
      chk("cmd_ready", 16'h0001, 16'(cmd_ready));
      cmd_op = op;
      cmd_addr = addr;
      cmd_code = code;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
      n = 0;
      while (rsp_done !== 1'b1 && n < 4000) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("rsp_done", 16'h0001, 16'(rsp_done));
      rdv = rsp_rdata;
      nk = rsp_nack;
      chk("scl idle", 16'h0001, 16'(smb_link_inst.scl));
      chk("sda idle", 16'h0001, 16'(smb_link_inst.sda));
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i) ^ 8'h3c;
      end
      repeat (12) @(posedge core_clk);
      #1 resetn = 1'b1;
      chk("busy after reset", 16'h0000, 16'(busy));
      run(OP_WORD_WR, TARGET_ADDR_DEF, 8'h90, 16'hbeef, rd, nack);
      chk("word write nack", 16'h0000, 16'(nack));
      chk("busy seen", 16'h0001, 16'(busy_seen));
      chk("word write low", 16'h00ef, 16'(mem[16]));
      chk("word write high", 16'h00be, 16'(mem[17]));
      chk("write addr byte", {8'h00, TARGET_ADDR_DEF, 1'b0}, 16'(mon_addr));
      chk("addr ack", 16'h0000, 16'(mon_ack));
      run(OP_WORD_WR, TARGET_ADDR_DEF, 8'hfe, 16'h1234, rd, nack);
      chk("top offset low", 16'h0034, 16'(mem[126]));
      chk("top offset high", 16'h0012, 16'(mem[127]));
      $display("test word write done");
      rd0 = rd_cnt;
      run(OP_WORD_RD, TARGET_ADDR_DEF, 8'h90, 16'h0000, rd, nack);
      chk("word read data", 16'hbeef, rd);
      chk("word read loads", 16'h0002, 16'(rd_cnt - rd0));
      chk("word read nack", 16'h0000, 16'(nack));
      chk("read addr byte", {8'h00, TARGET_ADDR_DEF, 1'b1}, 16'(mon_addr));
      run(OP_WORD_RD, TARGET_ADDR_DEF, 8'hfe, 16'h0000, rd, nack);
      chk("top word read", 16'h1234, rd);
      $display("test word read done");
      wr0 = wr_cnt;
      run(OP_BYTE_WR, TARGET_ADDR_DEF, 8'h85, 16'hff5a, rd, nack);
      chk("byte write nack", 16'h0000, 16'(nack));
      chk("byte write data", 16'h005a, 16'(mem[5]));
      chk("byte write next", 16'h003a, 16'(mem[6]));
      chk("byte write count", 16'h0001, 16'(wr_cnt - wr0));
      $display("test byte write done");
      rd0 = rd_cnt;
      run(OP_BYTE_RD, TARGET_ADDR_DEF, 8'h86, 16'h0000, rd, nack);
      chk("byte read fresh", 16'h003a, 16'(rd[7:0]));
      chk("byte read loads", 16'h0001, 16'(rd_cnt - rd0));
      run(OP_BYTE_RD, TARGET_ADDR_DEF, 8'h85, 16'h0000, rd, nack);
      chk("byte read stored", 16'h005a, 16'(rd[7:0]));
      chk("byte read nack", 16'h0000, 16'(nack));
      $display("test byte read done");
      // block commands are handed off: the data bytes are refused, nothing stored
      wr0 = wr_cnt;
      blk0 = blk_cnt;
      run(OP_WORD_WR, TARGET_ADDR_DEF, 8'h00, 16'hffff, rd, nack);
      chk("block nack", 16'h0001, 16'(nack));
      chk("block pulse", 16'h0001, 16'(blk_cnt - blk0));
      chk("block stores", 16'h0000, 16'(wr_cnt - wr0));
      chk("block offset0", 16'h003c, 16'(mem[0]));
      $display("test block command done");
      wr0 = wr_cnt;
      run(OP_WORD_WR, 7'h2b, 8'h90, 16'h0000, rd, nack);
      chk("foreign nack", 16'h0001, 16'(nack));
      chk("foreign ack bit", 16'h0001, 16'(mon_ack));
      chk("foreign stores", 16'h0000, 16'(wr_cnt - wr0));
      run(OP_BYTE_RD, TARGET_ADDR_DEF, 8'h90, 16'h0000, rd, nack);
      chk("after foreign", 16'h00ef, 16'(rd[7:0]));
      repeat (8) @(posedge core_clk);
      chk("busy idle", 16'h0000, 16'(busy));
      $display("test foreign address done");
      give_verdict();
   end

   initial begin
      #1000000;
      err_total++;
      $display("[ERR] watchdog expected done seen timeout");
      give_verdict();
   end
endmodule

//--- test/smb_link_checker.sv
/*
 * assertions on the two-wire link between the host end and the target end.
 * assumes the host runs with four core cycles per quarter link period.
 */
module smb_link_checker (
   input wire logic core_clk, // core clock
   input wire logic resetn, // asynchronous reset
   input wire logic host_scl_o, // host clock level
   input wire logic host_scl_oe, // host pulls clock
   input wire logic host_sda_o, // host data level
   input wire logic host_sda_oe, // host pulls data
   input wire logic tgt_sda_o, // target data level
   input wire logic tgt_sda_oe, // target pulls data
   input wire logic scl, // clock wire
   input wire logic sda // data wire
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------------
   // link shape
   // ----------------------------------------------------------------
   // both ends pulling data while the clock is high means a lost turn
   a_pull_only: assert property (
      (!host_scl_oe || !host_scl_o) && (!host_sda_oe || !host_sda_o)
      && (!tgt_sda_oe || !tgt_sda_o) && !(scl && host_sda_oe && tgt_sda_oe))
      else $error("link driver enabled at high level or data drivers collide");
   a_scl_high_min: assert property (
      $rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   a_scl_low_min: assert property (
      $fell(scl) |-> !scl [*4])
      else $error("clock low phase too short");
   // a start or repeated start pulls clock low one quarter later
   a_start_shape: assert property (
      scl && $fell(sda) |-> scl [*3] ##[1:2] !scl)
      else $error("start not followed by clock low");
   a_stop_release: assert property (
      scl && $rose(sda) |-> !tgt_sda_oe [*8])
      else $error("target drives data after stop");

   // ----------------------------------------------------------------
   // target turn on the data wire
   // ----------------------------------------------------------------
   a_tgt_turn_low: assert property (
      !$stable(tgt_sda_oe) |-> !scl)
      else $error("target changed data while clock high");
   // the target sees the clock through a synchroniser, so it cannot react at once
   a_tgt_sync_gap: assert property (
      $fell(scl) |-> $stable(tgt_sda_oe) [*2])
      else $error("target changed data too soon after clock fall");
   a_ack_holds: assert property (
      $rose(scl) && tgt_sda_oe |-> tgt_sda_oe [*8])
      else $error("target released data within clock high");
endmodule
